/* rtl/mps_pkg.sv */
package mps_pkg;

   // Special function register addresses.
   localparam logic [7:0] ADDR_PORT0_LATCH = 8'h80;
   localparam logic [7:0] ADDR_PTR_LOW     = 8'h82;
   localparam logic [7:0] ADDR_PTR_HIGH    = 8'h83;
   localparam logic [7:0] ADDR_STRETCH     = 8'h8e;
   localparam logic [7:0] ADDR_PORT1_LATCH = 8'h90;
   localparam logic [7:0] ADDR_PORT1_DIR   = 8'h91;
   localparam logic [7:0] ADDR_ERASE       = 8'h94;
   localparam logic [7:0] ADDR_EE_DATA     = 8'h9e;
   localparam logic [7:0] ADDR_EE_CTRL     = 8'h9f;
   localparam logic [7:0] ADDR_PORT2_LATCH = 8'ha0;
   localparam logic [7:0] ADDR_PORT2_DIR   = 8'ha1;
   localparam logic [7:0] ADDR_PORT0_DIR   = 8'ha2;
   localparam logic [7:0] ADDR_FLASH_CTRL  = 8'hb2;
   localparam logic [7:0] ADDR_FLASH_BANK  = 8'hb6;
   localparam logic [7:0] ADDR_PAGE_ADDR   = 8'hb7;

   // Field positions inside the flash control register.
   localparam int BIT_PWE     = 0;
   localparam int BIT_MEEN    = 1;
   localparam int BIT_PROT_CE = 4;
   localparam int BIT_PROT_BT = 5;
   localparam int BIT_LOCK    = 6;
   localparam int BIT_PREBOOT = 7;

   // Reset values.
   localparam logic [2:0] RST_STRETCH   = 3'h1;
   localparam logic [7:0] RST_PAGE_ADDR = 8'h00;
   localparam logic [7:0] RST_BYTE      = 8'h00;
   localparam logic [2:0] RST_BANK      = 3'h0;

   // Strobe timing: read strobes last stretch plus this, write address stretch plus this.
   localparam logic [3:0] RD_EXTRA = 4'h1;
   localparam logic [3:0] WR_EXTRA = 4'h2;

   // External memory strobes travel together.
   typedef struct packed {
      logic memaddr;
      logic memrd;
      logic memwr;
   } mps_strobe_t;

   typedef enum logic [1:0] {
      MPS_IDLE,
      MPS_ACTIVE,
      MPS_DONE
   } mps_state_t;

endpackage : mps_pkg

/* rtl/mps_sfr_bank.sv */
`timescale 1ns/100ps
module mps_sfr_bank
   import mps_pkg::*;
#(
   parameter int PORT_W = 8,
   parameter int LOC_W  = 8
) (
   input  wire logic                   clk,
   input  wire logic                   arst_n,
   // Core access to the special function registers.
   input  wire logic [7:0]             sfr_addr,
   input  wire logic                   sfr_wr,
   input  wire logic                   sfr_rd,
   input  wire logic [7:0]             sfr_wdata,
   output logic      [7:0]             sfr_rdata,
   // Digital I/O pins, four signals per pin.
   input  wire logic [2:0][PORT_W-1:0] pin_in,
   output logic      [2:0][PORT_W-1:0] pin_out,
   output logic      [2:0][PORT_W-1:0] pin_oe,
   output logic      [2:0][PORT_W-1:0] pin_change,
   // External data move requests from the core.
   input  wire logic                   xmove_req,
   input  wire logic                   xmove_write,
   input  wire logic [7:0]             xmove_wdata,
   output logic                        xmove_ready,
   output logic                        xmove_done,
   output logic      [7:0]             xmove_rdata,
   // External memory interface.
   output mps_strobe_t                 mem_strobe,
   output logic      [15:0]            mem_addr,
   output logic      [7:0]             mem_wdata,
   input  wire logic [7:0]             mem_rdata,
   // Flash controller side.
   output logic                        flash_wr,
   output logic                        mass_erase_start,
   output logic                        page_erase_start,
   output logic      [6:0]             page_erase_num,
   output logic      [2:0]             flash_bank,
   output logic                        readout_lock,
   input  wire logic [LOC_W-1:0]       engine_code_location,
   input  wire logic [LOC_W-1:0]       boot_size,
   input  wire logic                   preboot_active,
   // Serial EEPROM interface registers.
   output logic      [7:0]             ee_data,
   output logic      [7:0]             ee_ctrl
);

   // True when a page lies in a protection region that is switched on.
   function automatic logic page_blocked(input logic [6:0] page, input logic prot_ce,
                                         input logic prot_bt, input logic [LOC_W-1:0] loc,
                                         input logic [LOC_W-1:0] boot);
      logic [LOC_W:0] p;
      p = (LOC_W+1)'(page);
      page_blocked = (prot_ce && (p >= {1'b0, loc})) ||
                     (prot_bt && (p < {1'b0, boot}));
   endfunction : page_blocked

   // Address decode, reused for each port.
   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction : hit

   localparam logic [2:0][7:0] LATCH_ADDR = {ADDR_PORT2_LATCH, ADDR_PORT1_LATCH,
                                             ADDR_PORT0_LATCH};
   localparam logic [2:0][7:0] DIR_ADDR   = {ADDR_PORT2_DIR, ADDR_PORT1_DIR, ADDR_PORT0_DIR};

   logic [2:0][PORT_W-1:0] latch_q;
   logic [2:0][PORT_W-1:0] dir_q;
   logic [2:0][PORT_W-1:0] pin_prev_q;
   logic                   primed_q;
   logic [2:0]             stretch_q;
   logic [15:0]            ptr_q;
   logic                   pwe_q;
   logic                   meen_q;
   logic                   prot_ce_q;
   logic                   prot_bt_q;
   logic                   lock_q;
   logic [2:0]             bank_q;
   logic [7:0]             page_q;
   logic                   page_fresh_q;
   logic [7:0]             ee_data_q;
   logic [7:0]             ee_ctrl_q;
   logic [7:0]             rdata_q;
   logic                   erase_wr;
   logic                   page_ok;

   // Port latches and direction registers, one slice per port.
   for (genvar g = 0; g < 3; g++) begin : g_port
      always_ff @(posedge clk or negedge arst_n) begin
         if (!arst_n) begin
            latch_q[g] <= '0;
            dir_q[g]   <= '0;
         end else begin
            if (sfr_wr && hit(sfr_addr, LATCH_ADDR[g])) begin
               latch_q[g] <= sfr_wdata[PORT_W-1:0];
            end
            if (sfr_wr && hit(sfr_addr, DIR_ADDR[g])) begin
               dir_q[g] <= sfr_wdata[PORT_W-1:0];
            end
         end
      end
      assign pin_out[g] = latch_q[g];
      assign pin_oe[g]  = dir_q[g];
   end

   // Pin change events look at the pad level, not the direction, so self-made pulses count.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pin_prev_q <= '0;
         pin_change <= '0;
         primed_q   <= 1'b0; // The first cycle after reset only primes the history.
      end else begin
         pin_prev_q <= pin_in;
         primed_q   <= 1'b1;
         pin_change <= primed_q ? (pin_in ^ pin_prev_q) : '0;
      end
   end

   // Stretch setting, data pointer and serial EEPROM registers.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         stretch_q <= RST_STRETCH;
         ptr_q     <= '0;
         ee_data_q <= RST_BYTE;
         ee_ctrl_q <= RST_BYTE;
         bank_q    <= RST_BANK;
      end else if (sfr_wr) begin
         if (hit(sfr_addr, ADDR_STRETCH)) stretch_q <= sfr_wdata[2:0];
         if (hit(sfr_addr, ADDR_PTR_LOW)) ptr_q[7:0] <= sfr_wdata;
         if (hit(sfr_addr, ADDR_PTR_HIGH)) ptr_q[15:8] <= sfr_wdata;
         if (hit(sfr_addr, ADDR_EE_DATA)) ee_data_q <= sfr_wdata;
         if (hit(sfr_addr, ADDR_EE_CTRL)) ee_ctrl_q <= sfr_wdata;
         if (hit(sfr_addr, ADDR_FLASH_BANK)) bank_q <= sfr_wdata[2:0];
      end
   end

   assign erase_wr = sfr_wr && hit(sfr_addr, ADDR_ERASE);
   assign page_ok  = page_fresh_q && !page_blocked(page_q[6:0], prot_ce_q, prot_bt_q,
                                                  engine_code_location, boot_size);

   // Flash control bits; the enable bit is spent by the erase it starts.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         pwe_q     <= 1'b0;
         meen_q    <= 1'b0;
         prot_ce_q <= 1'b0;
         prot_bt_q <= 1'b0;
         lock_q    <= 1'b0;
      end else begin
         if (sfr_wr && hit(sfr_addr, ADDR_FLASH_CTRL)) begin
            pwe_q     <= sfr_wdata[BIT_PWE];
            meen_q    <= sfr_wdata[BIT_MEEN];
            prot_ce_q <= sfr_wdata[BIT_PROT_CE];
            prot_bt_q <= sfr_wdata[BIT_PROT_BT];
            lock_q    <= lock_q | sfr_wdata[BIT_LOCK];
         end else if (erase_wr) begin
            meen_q <= 1'b0;
         end
      end
   end

   // Page address must be written again before each page erase.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         page_q       <= RST_PAGE_ADDR;
         page_fresh_q <= 1'b0;
      end else if (sfr_wr && hit(sfr_addr, ADDR_PAGE_ADDR)) begin
         page_q       <= {1'b0, sfr_wdata[6:0]};
         page_fresh_q <= 1'b1;
      end else if (erase_wr && !meen_q) begin
         page_fresh_q <= 1'b0;
      end
   end

   // Erase launch; a blocked page simply gets no start pulse.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mass_erase_start <= 1'b0;
         page_erase_start <= 1'b0;
         page_erase_num   <= '0;
      end else begin
         mass_erase_start <= erase_wr && meen_q;
         page_erase_start <= erase_wr && !meen_q && page_ok;
         if (erase_wr) begin
            page_erase_num <= page_q[6:0];
         end
      end
   end

   // Read mux, registered; pins are read back rather than latches.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rdata_q <= RST_BYTE;
      end else if (sfr_rd) begin
         case (sfr_addr)
            ADDR_PORT0_LATCH: rdata_q <= 8'(pin_in[0]);
            ADDR_PORT1_LATCH: rdata_q <= 8'(pin_in[1]);
            ADDR_PORT2_LATCH: rdata_q <= 8'(pin_in[2]);
            ADDR_PORT0_DIR:   rdata_q <= 8'(dir_q[0]);
            ADDR_PORT1_DIR:   rdata_q <= 8'(dir_q[1]);
            ADDR_PORT2_DIR:   rdata_q <= 8'(dir_q[2]);
            ADDR_STRETCH:     rdata_q <= {5'h00, stretch_q};
            ADDR_PTR_LOW:     rdata_q <= ptr_q[7:0];
            ADDR_PTR_HIGH:    rdata_q <= ptr_q[15:8];
            ADDR_EE_DATA:     rdata_q <= ee_data_q;
            ADDR_EE_CTRL:     rdata_q <= ee_ctrl_q;
            ADDR_FLASH_BANK:  rdata_q <= {5'h00, bank_q};
            ADDR_PAGE_ADDR:   rdata_q <= page_q;
            ADDR_FLASH_CTRL:  rdata_q <= {preboot_active, lock_q, prot_bt_q, prot_ce_q,
                                          3'h0, pwe_q};
            default:          rdata_q <= RST_BYTE;
         endcase
      end
   end

   assign sfr_rdata    = rdata_q;
   assign flash_bank   = bank_q;
   assign readout_lock = lock_q;
   assign ee_data      = ee_data_q;
   assign ee_ctrl      = ee_ctrl_q;

   // External move sequencer; the stretch value is frozen per access.
   mps_state_t  state_q;
   logic [3:0]  cnt_q;
   logic [3:0]  len_q;
   logic [3:0]  wlen_q;
   logic [2:0]  s_q;
   logic        wr_q;
   logic        to_flash_q;
   mps_strobe_t strobe_q;

   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         state_q    <= MPS_IDLE;
         cnt_q      <= '0;
         len_q      <= '0;
         wlen_q     <= '0;
         s_q        <= RST_STRETCH;
         wr_q       <= 1'b0;
         to_flash_q <= 1'b0;
      end else begin
         case (state_q)
            MPS_IDLE: begin
               if (xmove_req) begin
                  state_q    <= MPS_ACTIVE;
                  cnt_q      <= '0;
                  s_q        <= stretch_q;
                  wr_q       <= xmove_write;
                  to_flash_q <= xmove_write && pwe_q;
                  len_q      <= xmove_write ? 4'(stretch_q) + WR_EXTRA
                                            : 4'(stretch_q) + RD_EXTRA;
                  wlen_q     <= (stretch_q < 3'h2) ? 4'h1 : 4'(stretch_q);
               end
            end
            MPS_ACTIVE: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == len_q - 4'h1) begin
                  state_q <= MPS_DONE;
               end
            end
            MPS_DONE: state_q <= MPS_IDLE;
            default:  state_q <= MPS_IDLE;
         endcase
      end
   end

   // Strobes are flopped one cycle behind the counter to keep them glitch free.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         strobe_q <= '0;
      end else begin
         strobe_q.memaddr <= (state_q == MPS_ACTIVE);
         strobe_q.memrd   <= (state_q == MPS_ACTIVE) && !wr_q;
         strobe_q.memwr   <= (state_q == MPS_ACTIVE) && wr_q && !to_flash_q &&
                             (cnt_q >= 4'h1) && (cnt_q <= wlen_q);
      end
   end

   // Address, write data, flash write pulse and captured read data.
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         mem_addr    <= '0;
         mem_wdata   <= '0;
         flash_wr    <= 1'b0;
         xmove_done  <= 1'b0;
         xmove_rdata <= '0;
      end else begin
         flash_wr   <= 1'b0;
         xmove_done <= (state_q == MPS_DONE);
         if (state_q == MPS_IDLE && xmove_req) begin
            mem_addr  <= ptr_q;
            mem_wdata <= xmove_wdata;
         end
         if (state_q == MPS_ACTIVE && cnt_q == 4'h0 && to_flash_q) flash_wr <= 1'b1;
         if (state_q == MPS_DONE && !wr_q) xmove_rdata <= mem_rdata;
      end
   end

   assign mem_strobe  = strobe_q;
   assign xmove_ready = (state_q == MPS_IDLE);

   // Strobe length counters read only by the checks below.
   logic [3:0] addr_len_q, wr_len_q;
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         addr_len_q <= '0;
         wr_len_q   <= '0;
      end else begin
         addr_len_q <= strobe_q.memaddr ? addr_len_q + 4'h1 : 4'h0;
         wr_len_q   <= strobe_q.memwr ? wr_len_q + 4'h1 : 4'h0;
      end
   end

   a_latch_drive: assert property (@(posedge clk) disable iff (!arst_n)
      sfr_wr && sfr_addr == ADDR_PORT0_LATCH |=> pin_out[0] == $past(sfr_wdata))
      else $error("Port 0 output does not follow latch write.");
   a_dir_write: assert property (@(posedge clk) disable iff (!arst_n)
      sfr_wr && sfr_addr == ADDR_PORT1_DIR |=> pin_oe[1] == $past(sfr_wdata))
      else $error("Port 1 direction not applied.");
   a_pin_readback: assert property (@(posedge clk) disable iff (!arst_n)
      sfr_rd && sfr_addr == ADDR_PORT2_LATCH |=> sfr_rdata == $past(pin_in[2]))
      else $error("Port read does not return pin level.");
   a_rd_strobe_width: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(strobe_q.memrd) |-> addr_len_q == 4'(s_q) + RD_EXTRA)
      else $error("Read strobe width wrong.");
   a_wr_addr_width: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(strobe_q.memaddr) && wr_q |-> addr_len_q == 4'(s_q) + WR_EXTRA)
      else $error("Write address width wrong.");
   a_wr_strobe_width: assert property (@(posedge clk) disable iff (!arst_n)
      $fell(strobe_q.memwr) |-> wr_len_q == ((s_q < 3'h2) ? 4'h1 : 4'(s_q)))
      else $error("Write strobe width wrong.");
   a_erase_blocked: assert property (@(posedge clk) disable iff (!arst_n)
      erase_wr && !meen_q && page_blocked(page_q[6:0], prot_ce_q, prot_bt_q,
         engine_code_location, boot_size) |=> !page_erase_start)
      else $error("Protected page erase was started.");
   a_mass_enable_spent: assert property (@(posedge clk) disable iff (!arst_n)
      mass_erase_start |-> !meen_q)
      else $error("Mass erase enable survived its erase.");
   a_lock_sticky: assert property (@(posedge clk) disable iff (!arst_n)
      readout_lock |=> readout_lock)
      else $error("Readout lock was cleared.");
   a_preboot_read: assert property (@(posedge clk) disable iff (!arst_n)
      sfr_rd && sfr_addr == ADDR_FLASH_CTRL |=> sfr_rdata[7] == $past(preboot_active))
      else $error("Preboot status misreported.");

endmodule : mps_sfr_bank

/* verif/mps_ram_model.sv */
`timescale 1ns/100ps
// Shared data RAM behind the external memory strobes, reduced to a read pattern.
module mps_ram_model
   import mps_pkg::*;
(
   input  wire logic        clk,
   input  wire mps_strobe_t mem_strobe,
   input  wire logic [15:0] mem_addr,
   output logic      [7:0]  mem_rdata
);
   logic       hold_q;
   logic [7:0] last_q;

   // Data stays one cycle after the read strobe drops, then it inverts every cycle so stale data matches only on every second cycle.
   always_ff @(posedge clk) begin
      hold_q <= mem_strobe.memrd;
      last_q <= mem_rdata;
   end

   // Each address answers with its own byte pattern.
   always_comb begin
      if (mem_strobe.memrd || hold_q) begin
         mem_rdata = mem_addr[7:0] ^ mem_addr[15:8] ^ 8'h5a;
      end else begin
         mem_rdata = ~last_q;
      end
   end
endmodule : mps_ram_model

/* verif/mps_sfr_bank_test.sv */
`timescale 1ns/100ps
module mps_sfr_bank_test;
   import mps_pkg::*;
   logic [2:0][7:0] pin_in, pin_out, pin_oe, pin_change, pad_ext;
   mps_strobe_t     mem_strobe;
   logic [15:0]     mem_addr, dp;
   logic [7:0]      sfr_addr, sfr_wdata, sfr_rdata, xmove_wdata, xmove_rdata, mem_wdata;
   logic [7:0]      mem_rdata, engine_code_location, boot_size, ee_data, ee_ctrl, v, dv;
   logic [6:0]      page_erase_num;
   logic [2:0]      flash_bank;
   logic            clk, arst_n, sfr_wr, sfr_rd, xmove_req, xmove_write, xmove_ready;
   logic            xmove_done, flash_wr, mass_erase_start, page_erase_start, readout_lock;
   logic            preboot_active, rd_seen;
   logic [7:0]      exp_q [$];
   logic [7:0]      la [3] = '{ADDR_PORT0_LATCH, ADDR_PORT1_LATCH, ADDR_PORT2_LATCH};
   logic [7:0]      da [3] = '{ADDR_PORT0_DIR, ADDR_PORT1_DIR, ADDR_PORT2_DIR};
   int              n_mismatch, samples_checked, p, s;
   integer          n_addr, n_rd, n_wr, n_fw, n_mass, n_page, n_chg;

   mps_sfr_bank DUT (.clk, .arst_n, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
      .pin_in, .pin_out, .pin_oe, .pin_change, .xmove_req, .xmove_write, .xmove_wdata,
      .xmove_ready, .xmove_done, .xmove_rdata, .mem_strobe, .mem_addr, .mem_wdata, .mem_rdata,
      .flash_wr, .mass_erase_start, .page_erase_start, .page_erase_num, .flash_bank,
      .readout_lock, .engine_code_location, .boot_size, .preboot_active, .ee_data, .ee_ctrl);

   mps_ram_model u_ram (.clk, .mem_strobe, .mem_addr, .mem_rdata);

   // A pad shows the driver where enabled and the outside level elsewhere.
   assign pin_in = (pin_out & pin_oe) | (pad_ext & ~pin_oe);

   always #4 clk = ~clk;

   // Tally strobe cycles and pulses; the oldest noted read value meets each read answer.
   always @(posedge clk) begin
      n_addr += mem_strobe.memaddr;
      n_rd += mem_strobe.memrd;
      n_wr += mem_strobe.memwr;
      n_fw += flash_wr;
      n_mass += mass_erase_start;
      n_page += page_erase_start;
      n_chg += (pin_change != '0);
      if (rd_seen) chk_byte(sfr_rdata, exp_q.pop_front());
      rd_seen <= sfr_rd;
   end

   task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
      samples_checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("[ERR] %0t byte got %h want %h", $time, got, want);
      end
   endtask : chk_byte

   task automatic chk_count(input integer got, input integer want);
      samples_checked++;
      if (got !== want) begin
         n_mismatch++;
         $display("[ERR] %0t count got %0d want %0d", $time, got, want);
      end
   endtask : chk_count

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk);
      sfr_addr = a;
      sfr_wdata = d;
      sfr_wr = 1'b1;
      @(negedge clk);
      sfr_wr = 1'b0;
   endtask : wr

   task automatic rd(input logic [7:0] a, input logic [7:0] want);
      @(negedge clk);
      sfr_addr = a;
      sfr_rd = 1'b1;
      exp_q.push_back(want);
      @(negedge clk);
      sfr_rd = 1'b0;
   endtask : rd

   // One external move; strobe widths are counted by the tally process.
   task automatic mv(input logic w, input logic [7:0] d, input int st, input logic fl);
      int k;
      n_addr = 0;
      n_rd = 0;
      n_wr = 0;
      n_fw = 0;
      k = 0;
      @(negedge clk);
      xmove_req = 1'b1;
      xmove_write = w;
      xmove_wdata = d;
      @(negedge clk);
      xmove_req = 1'b0;
      chk_byte({7'h0, xmove_ready}, 8'h00);
      while (xmove_done !== 1'b1 && k < 40) begin
         @(negedge clk);
         k++;
      end
      chk_count(k < 40, 1);
      if (!fl) chk_count(n_addr, st + (w ? 2 : 1));
      chk_count(n_rd, w ? 0 : st + 1);
      chk_count(n_wr, (w && !fl) ? (st < 2 ? 1 : st) : 0);
      chk_count(n_fw, (w && fl) ? 1 : 0);
      chk_byte(mem_addr[7:0], dp[7:0]);
      chk_byte(mem_addr[15:8], dp[15:8]);
      if (w) chk_byte(mem_wdata, d);
      chk_byte({7'h0, xmove_ready}, 8'h01);
      if (!w) chk_byte(xmove_rdata, dp[7:0] ^ dp[15:8] ^ 8'h5a);
   endtask : mv

   task automatic er(input int m, input int pg);
      n_mass = 0;
      n_page = 0;
      wr(ADDR_ERASE, 8'(p));
      repeat (3) @(negedge clk);
      chk_count(n_mass, m);
      chk_count(n_page, pg);
   endtask : er

   task automatic close_out;
      $display("comparisons %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : close_out

   // A hang is cut short well beyond the expected run of a few hundred cycles.
   initial begin
      #200000;
      n_mismatch++;
      close_out;
   end

   initial begin
      {clk, sfr_wr, sfr_rd, xmove_req, xmove_write, rd_seen} = '0;
      {sfr_addr, sfr_wdata, xmove_wdata, dp} = '0;
      engine_code_location = 8'h40;
      boot_size = 8'h04;
      preboot_active = 1'b1;
      arst_n = 1'b0;
      void'($urandom(33285));
      pad_ext = 24'($urandom);
      repeat (20) @(negedge clk);
      arst_n = 1'b1;
      rd(ADDR_STRETCH, {5'h0, RST_STRETCH});
      rd(ADDR_PAGE_ADDR, RST_PAGE_ADDR);
      rd(ADDR_FLASH_CTRL, 8'h80);
      rd(8'hc5, 8'h00);
      $display("test reset values done");
      for (p = 0; p < 3; p++) begin
         v = 8'($urandom);
         dv = 8'($urandom);
         wr(la[p], v);
         wr(da[p], dv);
         chk_byte(pin_out[p], v);
         chk_byte(pin_oe[p], dv);
         rd(da[p], dv);
         rd(la[p], (v & dv) | (pad_ext[p] & ~dv));
      end
      wr(ADDR_PORT1_DIR, 8'h0f);
      wr(ADDR_PORT1_LATCH, 8'h00);
      repeat (3) @(negedge clk);
      n_chg = 0;
      wr(ADDR_PORT1_LATCH, 8'h01);
      repeat (3) @(negedge clk);
      pad_ext[1][7] = ~pad_ext[1][7];
      repeat (3) @(negedge clk);
      chk_count(n_chg, 2);
      $display("test ports done");
      dp = 16'($urandom);
      wr(ADDR_PTR_LOW, dp[7:0]);
      wr(ADDR_PTR_HIGH, dp[15:8]);
      for (s = 0; s < 8; s++) begin
         wr(ADDR_STRETCH, 8'(s));
         mv(1'b0, 8'h00, s, 1'b0);
         mv(1'b1, 8'($urandom), s, 1'b0);
      end
      wr(ADDR_STRETCH, {5'h0, RST_STRETCH});
      wr(ADDR_FLASH_CTRL, 8'h01);
      mv(1'b1, 8'ha5, 1, 1'b1);
      wr(ADDR_FLASH_CTRL, 8'h00);
      $display("test external moves done");
      wr(ADDR_FLASH_CTRL, 8'h02);
      er(1, 0);
      er(0, 0);
      wr(ADDR_PAGE_ADDR, 8'h3f);
      er(0, 1);
      chk_byte({1'b0, page_erase_num}, 8'h3f);
      wr(ADDR_FLASH_CTRL, 8'h10);
      wr(ADDR_PAGE_ADDR, 8'h40);
      er(0, 0);
      wr(ADDR_PAGE_ADDR, 8'h3f);
      er(0, 1);
      wr(ADDR_FLASH_CTRL, 8'h20);
      wr(ADDR_PAGE_ADDR, 8'h03);
      er(0, 0);
      wr(ADDR_PAGE_ADDR, 8'h04);
      er(0, 1);
      rd(ADDR_PAGE_ADDR, 8'h04);
      $display("test erase done");
      wr(ADDR_FLASH_BANK, 8'h07);
      rd(ADDR_FLASH_BANK, 8'h07);
      chk_byte({5'h0, flash_bank}, 8'h07);
      wr(ADDR_EE_DATA, v);
      wr(ADDR_EE_CTRL, dv);
      rd(ADDR_EE_DATA, v);
      chk_byte(ee_ctrl, dv);
      chk_byte(ee_data, v);
      rd(ADDR_ERASE, 8'h00);
      wr(ADDR_FLASH_CTRL, 8'h7f);
      rd(ADDR_FLASH_CTRL, 8'hf1);
      preboot_active = 1'b0;
      wr(ADDR_FLASH_CTRL, 8'h00);
      rd(ADDR_FLASH_CTRL, 8'h40);
      chk_byte({7'h0, readout_lock}, 8'h01);
      $display("test flash control done");
      wr(ADDR_STRETCH, 8'h07);
      n_chg = 0;
      arst_n = 1'b0;
      repeat (2) @(negedge clk);
      arst_n = 1'b1;
      rd(ADDR_STRETCH, {5'h0, RST_STRETCH});
      rd(ADDR_FLASH_CTRL, 8'h00);
      repeat (2) @(negedge clk);
      chk_count(n_chg, 0);
      $display("test second reset done");
      close_out;
   end
endmodule : mps_sfr_bank_test
